// file: design/brad_decode.sv
// One master's decoder; every master uses this same module so the maps stay alike, except the boot region at 0x0, decoded only with HAS_BOOT_REMAP set.
module brad_decode #(
  parameter bit HAS_BOOT_REMAP = 1'b1
) (
  input wire logic [31:0] addr,
  input wire logic remap,
  input wire logic boot_from_rom,
  output brad_pkg::brad_sel_t sel,
  output logic [2:0] ext_cs,
  output logic [31:0] slave_addr
);
  logic [3:0] bank;
  logic [3:0] region;

  always_comb
  begin
    bank = addr[brad_pkg::BANK_LSB +: brad_pkg::BANK_W]; // see RULE2
    region = addr[brad_pkg::REGION_LSB +: brad_pkg::REGION_W];
    sel = brad_pkg::BRAD_SEL_NONE; // see RULE6
    ext_cs = brad_pkg::EXT_CS_BOOT;
    slave_addr = addr;
    case (bank) // see RULE1
      brad_pkg::BANK_INTERNAL:
      begin
        slave_addr = {12'h000, addr[19:0]}; // see RULE4
        case (region)
          brad_pkg::REGION_BOOT:
          begin
            if (HAS_BOOT_REMAP) // see RULE8
            begin
              if (remap)
                sel = brad_pkg::BRAD_SEL_SRAM0; // see RULE11
              else if (boot_from_rom)
                sel = brad_pkg::BRAD_SEL_ROM; // see RULE14
              else
              begin
                sel = brad_pkg::BRAD_SEL_EXT; // see RULE14
                ext_cs = brad_pkg::EXT_CS_BOOT;
                slave_addr = addr; // see RULE10
              end
            end
          end
          brad_pkg::REGION_ROM: sel = brad_pkg::BRAD_SEL_ROM; // see RULE15
          brad_pkg::REGION_SRAM0: sel = brad_pkg::BRAD_SEL_SRAM0; // see RULE15
          brad_pkg::REGION_SRAM1: sel = brad_pkg::BRAD_SEL_SRAM1; // see RULE15
          brad_pkg::REGION_USBH: sel = brad_pkg::BRAD_SEL_USBH; // see RULE15
          default: sel = brad_pkg::BRAD_SEL_NONE;
        endcase
      end
      brad_pkg::BANK_PERIPH: sel = brad_pkg::BRAD_SEL_APB; // see RULE5
      default:
      begin
        if (bank >= brad_pkg::BANK_EXT_FIRST && bank <= brad_pkg::BANK_EXT_LAST)
        begin
          sel = brad_pkg::BRAD_SEL_EXT; // see RULE3
          ext_cs = 3'(bank - brad_pkg::BANK_EXT_FIRST);
        end
      end
    endcase
  end
endmodule // brad_decode

// file: design/brad_top.sv
// How it works
// RULE1: The 32-bit space is cut into 16 banks of 256 Mbytes and each access selects exactly one of them.
// RULE2: The bank index is address bits 31 down to 28.
// RULE3: Banks 1 to 7 go to the external bus interface, bank n on external chip select n-1.
// RULE4: Bank 0 goes to internal memory and is split again into 1 Mbyte regions.
// RULE5: Bank 15 goes to the peripheral bridge.
// RULE6: An access to unoccupied space ends with an error response to its master.
// RULE7: Each master has its own decoder instance, all of the same structure.
// RULE8: For the instruction and data masters the region at 0x0 selects boot ROM, external boot or remapped SRAM.
// RULE9: After reset, fetches from 0x0 reach whichever boot slave is currently selected.
// RULE10: The first Mbyte, 0x0 to 0x000FFFFF, belongs to the selected boot memory.
// RULE11: With remap set, SRAM0 appears at 0x0 and the boot-select pin is ignored.
// RULE12: Software sets remap only after boot is done.
// RULE13: The boot-select pin is captured at reset release and held while remap is clear.
// RULE14: With remap clear, a captured 1 maps the ROM at 0x0 and a captured 0 maps external chip select 0.
// RULE15: ROM, SRAM0, SRAM1 and the USB host interface always stay at their own base addresses.
// RULE16: ROM and both SRAMs complete every access in one cycle.
module brad_top #(
  parameter int NUM_MASTERS = 2,
  parameter int NUM_BOOT_MASTERS = 2
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic boot_select_pin,
  input wire logic remap,
  input wire logic [NUM_MASTERS-1:0] m_valid,
  input wire logic [NUM_MASTERS-1:0] m_write,
  input wire logic [NUM_MASTERS*32-1:0] m_addr,
  input wire logic [NUM_MASTERS*32-1:0] m_wdata,
  output logic [NUM_MASTERS-1:0] m_ready,
  output logic [NUM_MASTERS-1:0] m_error,
  output logic [NUM_MASTERS*32-1:0] m_rdata,
  output logic [NUM_MASTERS-1:0] ext_req,
  output logic [NUM_MASTERS*3-1:0] external_chip_select,
  output logic [NUM_MASTERS-1:0] apb_req,
  output logic [NUM_MASTERS-1:0] usbh_req,
  output logic [NUM_MASTERS*32-1:0] s_addr,
  input wire logic [NUM_MASTERS-1:0] ext_ready,
  input wire logic [NUM_MASTERS*32-1:0] ext_rdata,
  input wire logic [NUM_MASTERS-1:0] apb_ready,
  input wire logic [NUM_MASTERS*32-1:0] apb_rdata,
  input wire logic [NUM_MASTERS-1:0] usbh_ready,
  input wire logic [NUM_MASTERS*32-1:0] usbh_rdata,
  output logic boot_from_rom
);
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_n;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic boot_cap_reg;
  logic boot_cap_next;
  logic boot_done_reg;
  logic boot_done_next;
  logic remap_s1_reg;
  logic remap_s2_reg;
  logic remap_s3_reg;
  logic fill_s1_reg;
  logic fill_s2_reg;

  // The reset is released through two flops so every flop leaves reset on the same edge.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // Pin inputs are synchronised; remap is assumed to come from a pin or foreign block too.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      remap_s1_reg <= 1'b0;
      remap_s2_reg <= 1'b0;
      remap_s3_reg <= 1'b0;
      fill_s1_reg <= 1'b0;
      fill_s2_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_s1_reg <= boot_select_pin;
      pin_s2_reg <= pin_s1_reg;
      remap_s1_reg <= remap; // see RULE12
      remap_s2_reg <= remap_s1_reg;
      remap_s3_reg <= remap_s2_reg;
      fill_s1_reg <= 1'b1;
      fill_s2_reg <= fill_s1_reg;
    end
  end

  // The pin is caught once, on the first enabled edge after its synchroniser has filled and remap_s2_reg equals remap_s3_reg.
  always_comb
  begin
    boot_cap_next = boot_cap_reg;
    boot_done_next = boot_done_reg;
    // Only settled copies are compared, since the first stage of a synchroniser may still be metastable.
    if (!boot_done_reg && fill_s2_reg && remap_s2_reg == remap_s3_reg)
    begin
      boot_cap_next = pin_s2_reg; // see RULE13
      boot_done_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_cap_reg <= 1'b0;
      boot_done_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      boot_cap_reg <= boot_cap_next;
      boot_done_reg <= boot_done_next;
    end
  end

  assign boot_from_rom = boot_cap_reg;

  // Internal memories live as flop arrays; a real chip would use macros of the same sizes.
  logic [31:0] rom_mem [brad_pkg::ROM_BYTES/4];
  logic [31:0] sram0_mem [brad_pkg::SRAM_BYTES/4];
  logic [31:0] sram1_mem [brad_pkg::SRAM_BYTES/4];

  initial
  begin
    for (int i = 0; i < brad_pkg::ROM_BYTES/4; i++)
      rom_mem[i] = 32'h00000000;
  end

  logic [NUM_MASTERS-1:0] s0_we;
  logic [NUM_MASTERS-1:0] s1_we;
  logic [NUM_MASTERS*12-1:0] s0_idx;
  logic [NUM_MASTERS*12-1:0] s1_idx;

  genvar g;
  generate
    for (g = 0; g < NUM_MASTERS; g++)
    begin : g_master
      brad_pkg::brad_sel_t sel;
      logic [2:0] cs;
      logic [31:0] saddr;
      logic [31:0] a;
      logic rdy_reg;
      logic rdy_next;
      logic err_reg;
      logic err_next;
      logic [31:0] rdata_reg;
      logic [31:0] rdata_next;
      logic boot_ok;
      logic ext_start;
      logic apb_start;
      logic usb_start;

      assign a = m_addr[g*32 +: 32];
      assign boot_ok = boot_done_reg;

      brad_decode #(
        .HAS_BOOT_REMAP(g < NUM_BOOT_MASTERS) // see RULE7
      ) u_dec (
        .addr(a),
        .remap(remap_s2_reg),
        .boot_from_rom(boot_cap_reg),
        .sel(sel),
        .ext_cs(cs),
        .slave_addr(saddr)
      );

      // The master holds its request until ready; slaves off-chip answer through their own ready.
      assign ext_start = m_valid[g] && boot_ok && sel == brad_pkg::BRAD_SEL_EXT && !rdy_reg;
      assign apb_start = m_valid[g] && boot_ok && sel == brad_pkg::BRAD_SEL_APB && !rdy_reg;
      assign usb_start = m_valid[g] && boot_ok && sel == brad_pkg::BRAD_SEL_USBH && !rdy_reg;
      assign ext_req[g] = ext_start; // see RULE3
      assign apb_req[g] = apb_start; // see RULE5
      assign usbh_req[g] = usb_start;
      assign external_chip_select[g*3 +: 3] = cs;
      assign s_addr[g*32 +: 32] = saddr;
      assign s0_we[g] = m_valid[g] && boot_ok && !rdy_reg && m_write[g] && sel == brad_pkg::BRAD_SEL_SRAM0;
      assign s1_we[g] = m_valid[g] && boot_ok && !rdy_reg && m_write[g] && sel == brad_pkg::BRAD_SEL_SRAM1;
      assign s0_idx[g*12 +: 12] = saddr[brad_pkg::SRAM_OFS_W-1:2];
      assign s1_idx[g*12 +: 12] = saddr[brad_pkg::SRAM_OFS_W-1:2];

      always_comb
      begin
        rdy_next = 1'b0;
        err_next = 1'b0;
        rdata_next = rdata_reg;
        // Requests wait until the boot choice is caught, so the first fetch sees it.
        if (m_valid[g] && boot_ok && !rdy_reg) // see RULE9
        begin
          case (sel)
            brad_pkg::BRAD_SEL_ROM:
            begin
              rdy_next = 1'b1; // see RULE16
              rdata_next = rom_mem[saddr[brad_pkg::ROM_OFS_W-1:2]];
            end
            brad_pkg::BRAD_SEL_SRAM0:
            begin
              rdy_next = 1'b1; // see RULE16
              rdata_next = sram0_mem[saddr[brad_pkg::SRAM_OFS_W-1:2]];
            end
            brad_pkg::BRAD_SEL_SRAM1:
            begin
              rdy_next = 1'b1; // see RULE16
              rdata_next = sram1_mem[saddr[brad_pkg::SRAM_OFS_W-1:2]];
            end
            brad_pkg::BRAD_SEL_EXT:
            begin
              rdy_next = ext_ready[g];
              rdata_next = ext_rdata[g*32 +: 32];
            end
            brad_pkg::BRAD_SEL_APB:
            begin
              rdy_next = apb_ready[g];
              rdata_next = apb_rdata[g*32 +: 32];
            end
            brad_pkg::BRAD_SEL_USBH:
            begin
              rdy_next = usbh_ready[g];
              rdata_next = usbh_rdata[g*32 +: 32];
            end
            default:
            begin
              rdy_next = 1'b1;
              err_next = 1'b1; // see RULE6
              rdata_next = 32'h00000000;
            end
          endcase
        end
      end

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rdy_reg <= 1'b0;
          err_reg <= 1'b0;
          rdata_reg <= 32'h00000000;
        end
        else if (clk_en)
        begin
          rdy_reg <= rdy_next;
          err_reg <= err_next;
          rdata_reg <= rdata_next;
        end
      end

      assign m_ready[g] = rdy_reg;
      assign m_error[g] = err_reg;
      assign m_rdata[g*32 +: 32] = rdata_reg;
    end
  endgenerate

  // Master 0 wins a same-cycle write to one SRAM word; the other write is lost, a documented limit.
  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      for (int k = NUM_MASTERS - 1; k >= 0; k--)
      begin
        if (s0_we[k])
          sram0_mem[s0_idx[k*12 +: 12]] <= m_wdata[k*32 +: 32];
        if (s1_we[k])
          sram1_mem[s1_idx[k*12 +: 12]] <= m_wdata[k*32 +: 32];
      end
    end
  end
endmodule // brad_top

// file: include/brad_pkg.sv
package brad_pkg;
  localparam int ADDR_W = 32;
  localparam int BANK_W = 4;
  localparam int BANK_LSB = 28;
  localparam int REGION_W = 4;
  localparam int REGION_LSB = 20;
  localparam logic [3:0] BANK_INTERNAL = 4'h0;
  localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
  localparam logic [3:0] BANK_EXT_LAST = 4'h7;
  localparam logic [3:0] BANK_PERIPH = 4'hF;
  localparam logic [3:0] REGION_BOOT = 4'h0;
  localparam logic [3:0] REGION_ROM = 4'h1;
  localparam logic [3:0] REGION_SRAM0 = 4'h2;
  localparam logic [3:0] REGION_SRAM1 = 4'h3;
  localparam logic [3:0] REGION_USBH = 4'h5;
  localparam int ROM_BYTES = 65536;
  localparam int SRAM_BYTES = 16384;
  localparam int ROM_OFS_W = 16;
  localparam int SRAM_OFS_W = 14;
  localparam int EXT_CS_W = 3;
  localparam logic [2:0] EXT_CS_BOOT = 3'h0;
  localparam int SEL_W = 7;

  typedef enum logic [6:0] {
    BRAD_SEL_NONE  = 7'h01,
    BRAD_SEL_ROM   = 7'h02,
    BRAD_SEL_SRAM0 = 7'h04,
    BRAD_SEL_SRAM1 = 7'h08,
    BRAD_SEL_USBH  = 7'h10,
    BRAD_SEL_EXT   = 7'h20,
    BRAD_SEL_APB   = 7'h40
  } brad_sel_t;
endpackage

// file: verification/brad_checker.sv
module brad_checker #(
  parameter int NUM_MASTERS = 2
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic remap,
  input wire logic [NUM_MASTERS-1:0] m_valid,
  input wire logic [NUM_MASTERS*32-1:0] m_addr,
  input wire logic [NUM_MASTERS-1:0] m_ready,
  input wire logic [NUM_MASTERS-1:0] m_error,
  input wire logic [NUM_MASTERS-1:0] ext_req,
  input wire logic [NUM_MASTERS*3-1:0] external_chip_select,
  input wire logic [NUM_MASTERS-1:0] apb_req,
  input wire logic [NUM_MASTERS-1:0] usbh_req,
  input wire logic [NUM_MASTERS*32-1:0] s_addr,
  input wire logic boot_from_rom
);
  // The boot capture is hidden, so the first answer stands in for it.
  logic seen_reg;
  logic [3:0] bk;
  logic go;
  assign bk = m_addr[31:28];
  assign go = seen_reg && clk_en && m_valid[0] && !m_ready[0];
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      seen_reg <= 1'b0;
    else if (m_ready != '0)
      seen_reg <= 1'b1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_ready_pulse: assert property (m_ready[0] |=> !m_ready[0])
    else $error("ready held longer than one cycle");
  a_sram_one_cycle: assert property (go && m_addr[31:20] inside {12'h002, 12'h003} |=> m_ready[0] && !m_error[0])
    else $error("SRAM access not answered in one cycle");
  a_unmapped_error: assert property (go && bk[3] && bk != 4'hF |=> m_ready[0] && m_error[0])
    else $error("unused bank gave no error");
  a_ext_cs_index: assert property (ext_req[0] && bk != 4'h0 |-> external_chip_select[2:0] == bk[2:0] - 3'h1)
    else $error("wrong chip select for bank");
  a_apb_route: assert property (go && bk == 4'hF |-> apb_req[0] && !ext_req[0])
    else $error("bank 15 not sent to peripheral bridge");
  a_single_slave: assert property ($onehot0({ext_req[0], apb_req[0], usbh_req[0]}))
    else $error("more than one slave requested");
  a_usbh_base: assert property (go && m_addr[31:20] == 12'h005 |-> usbh_req[0])
    else $error("USB host region moved");
  a_boot_ext: assert property (go && !remap && !boot_from_rom && m_addr[31:20] == 12'h000
    |-> ext_req[0] && external_chip_select[2:0] == 3'h0 && s_addr[31:0] == m_addr[31:0])
    else $error("external boot not on chip select 0");
  a_boot_held: assert property (seen_reg && $past(seen_reg) |-> $stable(boot_from_rom))
    else $error("boot choice changed after capture");
  c_error: cover property (m_ready[0] && m_error[0]);
  c_ext: cover property (ext_req[1]);
  c_apb: cover property (apb_req[0]);
endmodule // brad_checker

// file: verification/brad_slave_model.sv
module brad_slave_model #(
  parameter int NUM_MASTERS = 2,
  parameter int DELAY = 1,
  parameter logic [31:0] SALT = 32'hA0A00000
) (
  input wire logic core_clk,
  input wire logic [NUM_MASTERS-1:0] req,
  output logic [NUM_MASTERS-1:0] ready,
  output logic [NUM_MASTERS*32-1:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt [NUM_MASTERS];
  always_ff @(posedge core_clk)
  begin
    for (int g = 0; g < NUM_MASTERS; g++)
    begin
      ready[g] <= req[g] && !ready[g] && cnt[g] == DELAY;
      cnt[g] <= (req[g] && !ready[g]) ? cnt[g] + 1 : 0;
    end
  end
  // Data is good only beside ready; otherwise it is inverted so a late capture shows.
  always_comb
    for (int g = 0; g < NUM_MASTERS; g++)
      rdata[g*32+:32] = ready[g] ? SALT + 32'(g) : ~(SALT + 32'(g));
endmodule // brad_slave_model

// file: verification/brad_top_test.sv
module brad_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, nrst = 0, pin = 1, remap = 0, en = 1;
  logic [1:0] m_valid = '0, m_write = '0, m_ready, m_error, ext_req, apb_req, usbh_req, ext_rdy, apb_rdy, usb_rdy;
  logic [63:0] m_addr = '0, m_wdata = '0, m_rdata, s_addr, ext_rd, apb_rd, usb_rd;
  logic [5:0] cs;
  logic rom;
  logic [31:0] q;
  logic e;
  int errors = 0, checked = 0, lat;
  always #2 core_clk = ~core_clk;
  brad_top brad_top_i (.core_clk(core_clk), .nrst(nrst), .clk_en(en), .boot_select_pin(pin), .remap(remap),
    .m_valid(m_valid), .m_write(m_write), .m_addr(m_addr), .m_wdata(m_wdata), .m_ready(m_ready),
    .m_error(m_error), .m_rdata(m_rdata), .ext_req(ext_req), .external_chip_select(cs), .apb_req(apb_req),
    .usbh_req(usbh_req), .s_addr(s_addr), .ext_ready(ext_rdy), .ext_rdata(ext_rd), .apb_ready(apb_rdy),
    .apb_rdata(apb_rd), .usbh_ready(usb_rdy), .usbh_rdata(usb_rd), .boot_from_rom(rom));
  brad_slave_model #(.DELAY(3), .SALT(32'hE0E00000)) brad_slave_model_i (.core_clk(core_clk), .req(ext_req),
    .ready(ext_rdy), .rdata(ext_rd));
  brad_slave_model #(.DELAY(0)) brad_slave_model_i2 (.core_clk(core_clk), .req(apb_req),
    .ready(apb_rdy), .rdata(apb_rd));
  brad_slave_model #(.DELAY(1), .SALT(32'hC0C00000)) brad_slave_model_i3 (.core_clk(core_clk), .req(usbh_req),
    .ready(usb_rdy), .rdata(usb_rd));
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rst(input logic p);
    @(negedge core_clk);
    nrst = 1'b0;
    pin = p;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask
  // One word access; holds the request until the answer, then drops it.
  task automatic acc(input int m, input logic [31:0] a, input logic w, input logic [31:0] d);
    @(negedge core_clk);
    m_valid[m] = 1'b1;
    m_write[m] = w;
    m_addr[m*32+:32] = a;
    m_wdata[m*32+:32] = d;
    #1;
    if (a[31:28] != 4'h0 && !a[31])
      chk("chip select", 32'(a[30:28] - 3'h1), 32'(cs[m*3+:3]));
    lat = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      lat++;
    end while (m_ready[m] !== 1'b1 && lat < 50);
    if (lat >= 50)
    begin
      $display("Error ready expected 1 seen 0");
      errors++;
      complete_run();
    end
    q = m_rdata[m*32+:32];
    e = m_error[m];
    @(negedge core_clk);
    m_valid[m] = 1'b0;
  endtask
  task automatic t_rom_boot();
    rst(1'b1);
    chk("boot choice", 32'h1, 32'(rom));
    acc(0, 32'h00000000, 1'b0, 32'h0);
    chk("boot rom data", 32'h0, q);
    chk("boot latency", 32'h1, 32'(lat));
    acc(1, 32'h00100004, 1'b0, 32'h0);
    chk("rom error", 32'h0, 32'(e));
    $display("rom boot done");
  endtask
  task automatic t_sram();
    acc(0, 32'h00200010, 1'b1, 32'h11223344);
    acc(1, 32'h00300010, 1'b1, 32'h55667788);
    acc(1, 32'h00200010, 1'b0, 32'h0);
    chk("sram0 data", 32'h11223344, q);
    chk("sram latency", 32'h1, 32'(lat));
    acc(0, 32'h00300010, 1'b0, 32'h0);
    chk("sram1 data", 32'h55667788, q);
    $display("sram done");
  endtask
  task automatic t_unmapped();
    logic [31:0] t [5] = '{32'h80000000, 32'hE0000000, 32'h00400000, 32'h00600000, 32'h00F00000};
    for (int i = 0; i < 5; i++)
    begin
      acc(i % 2, t[i], 1'b0, 32'h0);
      chk("abort", 32'h1, 32'(e));
      chk("abort latency", 32'h1, 32'(lat));
    end
    $display("unmapped done");
  endtask
  // A request made while the clock enable is low must wait, then finish in one enabled cycle.
  task automatic t_freeze();
    @(negedge core_clk);
    en = 1'b0;
    m_valid[0] = 1'b1;
    m_write[0] = 1'b0;
    m_addr[31:0] = 32'h00200010;
    repeat (3) @(negedge core_clk);
    chk("frozen ready", 32'h0, 32'(m_ready[0]));
    en = 1'b1;
    @(posedge core_clk);
    #1;
    chk("thawed ready", 32'h1, 32'(m_ready[0]));
    chk("thawed data", 32'h11223344, m_rdata[31:0]);
    @(negedge core_clk);
    m_valid[0] = 1'b0;
    $display("freeze done");
  endtask
  task automatic t_ext();
    for (int b = 1; b < 8; b++)
    begin
      acc(b % 2, (32'(b) << 28) | 32'h40, 1'b0, 32'h0);
      chk("ext data", 32'hE0E00000 + 32'(b % 2), q);
    end
    acc(0, 32'hF0000100, 1'b0, 32'h0);
    chk("apb data", 32'hA0A00000, q);
    acc(1, 32'h00500020, 1'b0, 32'h0);
    chk("usb data", 32'hC0C00001, q);
    chk("usb slave address", 32'h00000020, s_addr[63:32]);
    $display("external and peripheral done");
  endtask
  task automatic t_remap();
    pin = 1'b0;
    remap = 1'b1;
    repeat (4) @(negedge core_clk);
    acc(0, 32'h00000010, 1'b0, 32'h0);
    chk("remapped sram0", 32'h11223344, q);
    $display("remap done");
  endtask
  task automatic t_ext_boot();
    remap = 1'b0;
    rst(1'b0);
    chk("boot choice", 32'h0, 32'(rom));
    acc(0, 32'h00000040, 1'b0, 32'h0);
    chk("ext boot data", 32'hE0E00000, q);
    $display("external boot done");
  endtask
  initial
  begin
    t_rom_boot();
    t_sram();
    t_unmapped();
    t_freeze();
    t_ext();
    t_remap();
    t_ext_boot();
    complete_run();
  end
endmodule // brad_top_test
bind brad_top brad_checker #(.NUM_MASTERS(NUM_MASTERS)) brad_checker_i (.core_clk(core_clk), .nrst(nrst),
  .clk_en(clk_en), .remap(remap), .m_valid(m_valid), .m_addr(m_addr), .m_ready(m_ready),
  .m_error(m_error), .ext_req(ext_req),
  .external_chip_select(external_chip_select), .apb_req(apb_req), .usbh_req(usbh_req), .s_addr(s_addr),
  .boot_from_rom(boot_from_rom));
